// File: rtl/eii_edge_det.sv
`timescale 1ns/1ps

// Two-flop synchroniser followed by a selectable edge detector and a
// sticky pending flag.
module eii_edge_det (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  input  wire logic rise_sel,
  input  wire logic enable,
  input  wire logic clear,
  output logic      pend
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pend;
  } eii_det_st_t;

  eii_det_st_t st_q;
  eii_det_st_t st_d;
  logic        edge_hit;

  always_comb begin
    st_d      = st_q;
    st_d.s1   = pin_in;
    st_d.s2   = st_q.s1;
    st_d.prev = st_q.s2;
    edge_hit = enable &&
               (rise_sel ? (st_q.s2 && !st_q.prev)
                         : (!st_q.s2 && st_q.prev));
    // Set wins over a clear in the same cycle.
    if (edge_hit) begin
      st_d.pend = 1'b1;
    end else if (clear) begin
      st_d.pend = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pend = st_q.pend;

endmodule // eii_edge_det

// File: rtl/eii_ext_irq.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Nonmaskable interrupt is raised only on a rising edge, never a level.
// - Four external interrupts are edge-driven, polarity chosen per bit.
// - With the GPIO variant pins are bidirectional, interrupt after reset.
// - On that variant edge detection also depends on GPIO register settings.
module eii_ext_irq
  import eii_pkg::*;
#(
  parameter bit HAS_GPIO = 1'b1
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   nmi_in,
  input  wire logic [EII_NUM_EXT-1:0] ext_irq_pin_i,
  output logic      [EII_NUM_EXT-1:0] ext_irq_pin_o,
  output logic      [EII_NUM_EXT-1:0] ext_irq_pin_oe_n,
  input  wire logic [EII_NUM_EXT-1:0] irq_edge_polarity_field,
  input  wire logic                   pol_wr,
  input  wire eii_gpio_cfg_t          gpio_cfg_in,
  input  wire logic                   gpio_cfg_wr,
  input  wire eii_irq_vec_t           irq_ack,
  input  wire logic [1:0]             emul_mode_select,
  input  wire logic                   dev_reset_n,
  output eii_irq_vec_t                irq_pending,
  output logic      [EII_NUM_EXT-1:0] gpio_rd_level,
  output logic                        bscan_mode,
  output logic                        emul_mode,
  output logic                        mode_reserved
);

  typedef struct packed {
    logic [EII_NUM_EXT-1:0] pol;
    eii_gpio_cfg_t          gpio;
    logic [EII_NUM_EXT-1:0] rd_level;
    logic                   bscan;
    logic                   emul;
    logic                   rsvd;
  } eii_top_st_t;

  eii_top_st_t            st_q;
  eii_top_st_t            st_d;
  logic [EII_NUM_EXT-1:0] ext_en;
  logic [EII_NUM_EXT-1:0] ext_pend;
  logic                   nmi_pend;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_d = st_q;
    if (pol_wr) begin
      st_d.pol = irq_edge_polarity_field;
    end
    if (gpio_cfg_wr && HAS_GPIO) begin
      st_d.gpio = gpio_cfg_in;
    end
    st_d.rd_level = ext_irq_pin_i;
    st_d.bscan = (emul_mode_select == EII_EMU_BSCAN);
    st_d.emul  = (emul_mode_select == EII_EMU_EMUL);
    st_d.rsvd  = !st_d.bscan && !st_d.emul;
    if (st_d.bscan && dev_reset_n) begin
      st_d.bscan = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q             <= '0;
      st_q.pol         <= EII_POL_RST;
      st_q.gpio.dir    <= EII_GPIO_DIR_RST;
      st_q.gpio.irq_en <= EII_IRQ_EN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  eii_edge_det u_nmi (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   (nmi_in),
    .rise_sel (1'b1),
    .enable   (1'b1),
    .clear    (irq_ack.nmi),
    .pend     (nmi_pend)
  );

  genvar gi;
  generate
    for (gi = 0; gi < EII_NUM_EXT; gi++) begin : g_ext
      assign ext_en[gi] = HAS_GPIO ? (st_q.gpio.irq_en[gi] &&
                                      !st_q.gpio.dir[gi]) : 1'b1;
      eii_edge_det u_ext (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   (ext_irq_pin_i[gi]),
        .rise_sel (st_q.pol[gi]),
        .enable   (ext_en[gi]),
        .clear    (irq_ack.ext[gi]),
        .pend     (ext_pend[gi])
      );
    end
  endgenerate

  assign ext_irq_pin_o    = st_q.gpio.out;
  assign ext_irq_pin_oe_n = HAS_GPIO ? ~st_q.gpio.dir : {EII_NUM_EXT{1'b1}};

  assign irq_pending.nmi = nmi_pend;
  assign irq_pending.ext = ext_pend;
  assign gpio_rd_level   = st_q.rd_level;
  assign bscan_mode      = st_q.bscan;
  assign emul_mode       = st_q.emul;
  assign mode_reserved   = st_q.rsvd;

  //////////////////////////////////////////////////////////////////////////////

  logic                   nmi_s2_h;
  logic                   nmi_prev_h;
  logic [EII_NUM_EXT-1:0] ext_s2_h;
  logic [EII_NUM_EXT-1:0] ext_prev_h;
  assign nmi_s2_h   = u_nmi.st_q.s2;
  assign nmi_prev_h = u_nmi.st_q.prev;
  for (genvar hi = 0; hi < EII_NUM_EXT; hi++) begin : g_h
    assign ext_s2_h[hi]   = g_ext[hi].u_ext.st_q.s2;
    assign ext_prev_h[hi] = g_ext[hi].u_ext.st_q.prev;
  end

  property p_nmi_rise;
    @(posedge sys_clk) disable iff (rst)
      (nmi_s2_h && !nmi_prev_h) |=> irq_pending.nmi;
  endproperty
  a_nmi_rise: assert property (p_nmi_rise)
    else $error("NMI rising edge not latched");

  property p_nmi_level;
    @(posedge sys_clk) disable iff (rst)
      (!irq_pending.nmi && !(nmi_s2_h && !nmi_prev_h)) |=> !irq_pending.nmi;
  endproperty
  a_nmi_level: assert property (p_nmi_level)
    else $error("NMI raised without a rising edge");

  property p_ext_pol;
    @(posedge sys_clk) disable iff (rst)
      (ext_en[0] && (st_q.pol[0] ? (ext_s2_h[0] && !ext_prev_h[0])
                                 : (!ext_s2_h[0] && ext_prev_h[0])))
      |=> irq_pending.ext[0];
  endproperty
  a_ext_pol: assert property (p_ext_pol)
    else $error("External edge of selected polarity missed");

  property p_ext_no_edge;
    @(posedge sys_clk) disable iff (rst)
      (!irq_pending.ext[1] && ext_s2_h[1] == ext_prev_h[1])
      |=> !irq_pending.ext[1];
  endproperty
  a_ext_no_edge: assert property (p_ext_no_edge)
    else $error("External pending set without an edge");

  property p_sticky;
    @(posedge sys_clk) disable iff (rst)
      (irq_pending.ext[2] && !irq_ack.ext[2]) |=> irq_pending.ext[2];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Pending flag dropped without acknowledge");

  property p_dir_default;
    @(posedge sys_clk) $fell(rst) |-> ext_irq_pin_oe_n == 4'hf;
  endproperty
  a_dir_default: assert property (p_dir_default)
    else $error("Shared pins not inputs after reset");

  property p_gpio_gate;
    @(posedge sys_clk) disable iff (rst)
      (!ext_en[3] && !irq_pending.ext[3]) |=> !irq_pending.ext[3];
  endproperty
  a_gpio_gate: assert property (p_gpio_gate)
    else $error("Edge detected while GPIO setting blocks it");

  property p_bscan;
    @(posedge sys_clk) disable iff (rst)
      bscan_mode |-> $past(emul_mode_select) == 2'h0 && !$past(dev_reset_n);
  endproperty
  a_bscan: assert property (p_bscan)
    else $error("Boundary scan without mode pins and reset low");

  property p_mode_dec;
    @(posedge sys_clk) disable iff (rst)
      !$past(rst) && $past(emul_mode_select) == 2'h3
      |-> emul_mode && !mode_reserved;
  endproperty
  a_mode_dec: assert property (p_mode_dec)
    else $error("Emulation mode decode wrong");

  property p_bscan_set;
    @(posedge sys_clk) disable iff (rst)
      !$past(rst) && $past(emul_mode_select) == 2'h0 && !$past(dev_reset_n)
      |-> bscan_mode;
  endproperty
  a_bscan_set: assert property (p_bscan_set)
    else $error("Boundary scan not entered with mode pins and reset low");

  property p_ack_clear;
    @(posedge sys_clk) disable iff (rst)
      (irq_pending.nmi && irq_ack.nmi && !(nmi_s2_h && !nmi_prev_h))
      |=> !irq_pending.nmi;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("NMI pending not cleared by acknowledge");

  property p_dir_hold;
    @(posedge sys_clk) disable iff (rst)
      (!$past(rst) && !$past(gpio_cfg_wr)) |-> $stable(ext_irq_pin_oe_n);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("Pin direction changed without a settings write");

  property p_rd_level;
    @(posedge sys_clk) disable iff (rst)
      !$past(rst) |-> gpio_rd_level == $past(ext_irq_pin_i);
  endproperty
  a_rd_level: assert property (p_rd_level)
    else $error("Pin read level does not follow the pins");

endmodule // eii_ext_irq

// File: rtl/eii_pkg.sv
package eii_pkg;

  localparam int unsigned EII_NUM_EXT = 4;

  // Emulation mode-select decode.
  localparam logic [1:0] EII_EMU_BSCAN = 2'h0;
  localparam logic [1:0] EII_EMU_EMUL  = 2'h3;

  // Reset values.
  localparam logic [3:0] EII_POL_RST   = 4'h0;
  localparam logic [3:0] EII_GPIO_DIR_RST = 4'h0;
  localparam logic [3:0] EII_IRQ_EN_RST   = 4'hf;

  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] out;
    logic [3:0] irq_en;
  } eii_gpio_cfg_t;

  typedef struct packed {
    logic       nmi;
    logic [3:0] ext;
  } eii_irq_vec_t;

endpackage

// File: test/eii_src_model.sv
`timescale 1ns/1ps

// Interrupt sources on the far side of the shared pins and the NMI pin.
module eii_src_model (
  input  wire logic [4:0] lvl_req,
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe_n,
  output logic            nmi_in,
  output logic [3:0]      pin_i
);
  assign nmi_in = lvl_req[4];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_i[i] = pin_oe_n[i] ? lvl_req[i] : pin_o[i];
    end
  end
endmodule // eii_src_model

// File: test/ext_interrupt_edge_inputs_bench.sv
`timescale 1ns/1ps

module ext_interrupt_edge_inputs_bench;
  import eii_pkg::*;
  logic          sys_clk, rst, pol_wr, cfg_wr, dev_rst_n, nmi;
  logic          bscan, emul, resv;
  logic [4:0]    lvl, s1, s2, s3, eq, mp;
  logic [3:0]    pol, pin_i, pin_o, oe_n, rd, mpol, men, mdir, wire_q;
  logic [3:0]    mout;
  logic [2:0]    mm;
  logic [1:0]    msel;
  logic [31:0]   seed = 32'h665f072d;
  logic [31:0]   r;
  eii_gpio_cfg_t cfg;
  eii_irq_vec_t  ack, pend;
  int            fails, comparisons, cyc;

  eii_src_model u_src (.lvl_req(lvl), .pin_o(pin_o), .pin_oe_n(oe_n),
    .nmi_in(nmi), .pin_i(pin_i));

  eii_ext_irq #(.HAS_GPIO(1'b1)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .nmi_in(nmi), .ext_irq_pin_i(pin_i), .ext_irq_pin_o(pin_o),
    .ext_irq_pin_oe_n(oe_n), .irq_edge_polarity_field(pol),
    .pol_wr(pol_wr), .gpio_cfg_in(cfg), .gpio_cfg_wr(cfg_wr),
    .irq_ack(ack), .emul_mode_select(msel),
    .dev_reset_n(dev_rst_n), .irq_pending(pend), .gpio_rd_level(rd),
    .bscan_mode(bscan), .emul_mode(emul), .mode_reserved(resv));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference model: two sync stages, previous sample, sticky flag.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      eq[i] = men[i] & ~mdir[i] & (mpol[i] ? s2[i] & ~s3[i]
                                           : ~s2[i] & s3[i]);
    end
    eq[4] = s2[4] & ~s3[4];
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      {s1, s2, s3, mp, mm} <= '0;
      wire_q <= 4'h0;
      mout <= 4'h0;
      mpol <= EII_POL_RST;
      men  <= EII_IRQ_EN_RST;
      mdir <= EII_GPIO_DIR_RST;
    end else begin
      s1 <= {nmi, pin_i};
      s2 <= s1;
      s3 <= s2;
      mp <= (mp & ~ack) | eq;
      if (pol_wr) mpol <= pol;
      if (cfg_wr) begin
        men  <= cfg.irq_en;
        mdir <= cfg.dir;
        mout <= cfg.out;
      end
      wire_q <= pin_i;
      mm <= {msel == 2'h0 && !dev_rst_n, msel == 2'h3,
             msel == 2'h1 || msel == 2'h2};
    end
  end

  always @(negedge sys_clk) begin
    if (!rst) begin
      chk({3'h0, pend}, {3'h0, mp});
      chk({4'h0, rd}, {4'h0, wire_q});
      chk({oe_n, pin_o}, {~mdir, mout});
      chk({5'h0, bscan, emul, resv}, {5'h0, mm});
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      report_and_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    rst = 1'b1; pol_wr = 1'b0; cfg_wr = 1'b0; cfg = '0; pol = 4'h0;
    lvl = 5'h0; ack = '0; msel = 2'h3; dev_rst_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 40; k++) begin
      lvl <= 5'h0;
      ack <= '0;
      repeat (6) @(posedge sys_clk);
      r = rnd();
      pol <= r[23:20];
      pol_wr <= 1'b1;
      cfg_wr <= k[0];
      cfg <= {r[11:8] & {4{k > 3}}, r[7:4], r[3:0] | {4{k < 2}}};
      @(posedge sys_clk);
      pol_wr <= 1'b0;
      cfg_wr <= 1'b0;
      repeat (30) begin
        r = rnd();
        lvl <= r[5] ? r[4:0] : lvl;
        ack <= (r[9:8] == 2'h0) ? r[14:10] : 5'h0;
        msel <= {2{r[16]}};
        dev_rst_n <= r[18];
        @(posedge sys_clk);
      end
    end
    report_and_stop;
  end
endmodule // ext_interrupt_edge_inputs_bench
